// file: scbm_core.sv
// single cycle byte multiplier with product register pair
// Notes on behaviour
// [RULE1] a full byte by byte multiply finishes in one instruction cycle
// [RULE2] operands unsigned; whole sixteen-bit product kept, no sign extension
// [RULE3] upper product byte goes to high register, lower to low register
// [RULE4] multiply leaves every arithmetic status flag unchanged
// [RULE5] one operand from working register, other from addressed file register
// [RULE6] software builds signed products by subtracting from the high byte
// [RULE7] software builds 32-bit products from four weighted partial products
// [RULE8] product pair holds until next multiply or direct write; readable
`timescale 1ns/10ps
module scbm_core
  import scbm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic mul_exec,
  input wire logic [7:0] working_register,
  input wire logic [7:0] file_operand,
  input wire logic wr_high,
  input wire logic wr_low,
  input wire logic [7:0] wr_data,
  input wire logic flags_we,
  input wire logic [7:0] flags_wdata,
  output logic [7:0] product_high_byte,
  output logic [7:0] product_low_byte,
  output logic [7:0] arithmetic_status_register,
  output logic mul_done
);

  // ----------------------------------------
  // multiplier array
  // ----------------------------------------
  scbm_mul_if mi ();
  assign mi.op_a = working_register; // [RULE5]
  assign mi.op_b = file_operand; // [RULE5]

  scbm_array u_array (
    .mi(mi)
  );

  // ----------------------------------------
  // request decode
  // ----------------------------------------
  logic hi_wr_req;
  logic lo_wr_req;
  logic flag_wr_req;

  // a multiply in the same cycle shadows every direct write
  assign hi_wr_req = wr_high && !mul_exec; // [RULE8]
  assign lo_wr_req = wr_low && !mul_exec; // [RULE8]
  // flags never move in a multiply cycle
  assign flag_wr_req = flags_we && !mul_exec; // [RULE4]

  // ----------------------------------------
  // state update
  // ----------------------------------------
  scbm_state_t state_reg;
  scbm_state_t state_next;

  always_comb begin
    state_next = state_reg;
    state_next.done = 1'b0;
    if (mul_exec) begin
      state_next.prod_hi = mi.product[15:8]; // [RULE3] [RULE2]
      state_next.prod_lo = mi.product[7:0]; // [RULE3] [RULE1]
      state_next.done = 1'b1;
    end
    // direct software writes; otherwise pair holds
    if (hi_wr_req) begin
      state_next.prod_hi = wr_data; // [RULE8]
    end
    if (lo_wr_req) begin
      state_next.prod_lo = wr_data; // [RULE8]
    end
    // flags follow only their own write port, never the multiply
    if (flag_wr_req) begin
      state_next.flags = flags_wdata; // [RULE4]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg.prod_hi <= SCBM_PROD_RST;
      state_reg.prod_lo <= SCBM_PROD_RST;
      state_reg.flags <= SCBM_FLAGS_RST;
      state_reg.done <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign product_high_byte = state_reg.prod_hi;
  assign product_low_byte = state_reg.prod_lo;
  assign arithmetic_status_register = state_reg.flags;
  assign mul_done = state_reg.done;

  // ----------------------------------------
  // assertion sequences
  // ----------------------------------------
  // multiply request outside reset
  sequence s_mul_issue;
    mul_exec && !rst;
  endsequence

  // whole product pair as one word
  sequence s_mul_result(logic [15:0] p);
    {product_high_byte, product_low_byte} == p;
  endsequence

  // direct writes that no multiply shadows
  sequence s_high_write;
    !mul_exec && wr_high;
  endsequence

  sequence s_low_write;
    !mul_exec && wr_low;
  endsequence

  sequence s_flag_write;
    !mul_exec && flags_we;
  endsequence

  // ----------------------------------------
  // timing of the multiply
  // ----------------------------------------
  // result and done one edge after issue
  a_mul_one_cycle: assert property (@(posedge clk) // [RULE1]
    disable iff (rst) s_mul_issue |=> mul_done)
    else $error("multiply did not finish in one cycle");

  a_done_pulse: assert property (@(posedge clk) // [RULE1]
    disable iff (rst) !mul_exec |=> !mul_done)
    else $error("done without a multiply");

  a_done_follows: assert property (@(posedge clk) // [RULE1]
    disable iff (rst) mul_done |-> $past(mul_exec))
    else $error("done not preceded by a multiply");

  // ----------------------------------------
  // product value and split
  // ----------------------------------------
  a_unsigned_full_product: assert property (@(posedge clk) // [RULE2]
    disable iff (rst)
    mul_exec |=> s_mul_result(16'($past(working_register)) *
      16'($past(file_operand))))
    else $error("product differs from unsigned full product");

  // largest operands must not wrap or sign extend
  a_max_product: assert property (@(posedge clk) // [RULE2]
    disable iff (rst)
    mul_exec && working_register == 8'hFF && file_operand == 8'hFF
      |=> s_mul_result(16'hFE01))
    else $error("largest product truncated or sign extended");

  a_high_byte_split: assert property (@(posedge clk) // [RULE3]
    disable iff (rst)
    mul_exec |=> product_high_byte ==
      8'((16'($past(working_register)) * 16'($past(file_operand))) >> 8))
    else $error("high product byte wrong");

  a_low_byte_split: assert property (@(posedge clk) // [RULE3]
    disable iff (rst)
    mul_exec |=> product_low_byte ==
      8'(16'($past(working_register)) * 16'($past(file_operand))))
    else $error("low product byte wrong");

  // a zero on either side forces a zero pair
  a_operand_source: assert property (@(posedge clk) // [RULE5]
    disable iff (rst)
    mul_exec && working_register == 8'h00 |=> s_mul_result(16'h0000))
    else $error("operand not taken from working register");

  a_operand_file: assert property (@(posedge clk) // [RULE5]
    disable iff (rst)
    mul_exec && file_operand == 8'h00 |=> s_mul_result(16'h0000))
    else $error("operand not taken from file register");

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  a_flags_untouched: assert property (@(posedge clk) // [RULE4]
    disable iff (rst) mul_exec |=> $stable(arithmetic_status_register))
    else $error("multiply changed status flags");

  // a flag write that meets a multiply is dropped
  a_flags_refused: assert property (@(posedge clk) // [RULE4]
    disable iff (rst)
    mul_exec && flags_we |=> $stable(arithmetic_status_register))
    else $error("flag write landed during a multiply");

  a_flag_write: assert property (@(posedge clk) // [RULE4]
    disable iff (rst)
    s_flag_write |=> arithmetic_status_register == $past(flags_wdata))
    else $error("flag write lost");

  // ----------------------------------------
  // product pair hold and direct writes
  // ----------------------------------------
  a_product_hold: assert property (@(posedge clk) // [RULE8]
    disable iff (rst)
    !mul_exec && !wr_high && !wr_low |=> $stable(product_high_byte)
      && $stable(product_low_byte))
    else $error("product pair changed without cause");

  a_direct_write_high: assert property (@(posedge clk) // [RULE8]
    disable iff (rst)
    s_high_write |=> product_high_byte == $past(wr_data))
    else $error("direct write to high byte lost");

  a_direct_write_low: assert property (@(posedge clk) // [RULE8]
    disable iff (rst)
    s_low_write |=> product_low_byte == $past(wr_data))
    else $error("direct write to low byte lost");

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  // no disable here: these watch the reset itself
  a_reset_product: assert property (@(posedge clk) // [RULE8]
    rst |=> product_high_byte == SCBM_PROD_RST
      && product_low_byte == SCBM_PROD_RST && !mul_done)
    else $error("product pair not cleared by reset");

  a_reset_flags: assert property (@(posedge clk) // [RULE4]
    rst |=> arithmetic_status_register == SCBM_FLAGS_RST)
    else $error("status flags not cleared by reset");

endmodule : scbm_core

// file: scbm_pkg.sv
// package: constants and types for the single cycle byte multiplier
package scbm_pkg;
  localparam int SCBM_OPW = 8;
  localparam int SCBM_PRW = 16;
  localparam logic [7:0] SCBM_PROD_RST = 8'h00;
  localparam logic [7:0] SCBM_FLAGS_RST = 8'h00;
  localparam int SCBM_MUL_CYCLES = 1;

  typedef enum logic [1:0] {
    SCBM_OP_NONE,
    SCBM_OP_MUL,
    SCBM_OP_WR_HI,
    SCBM_OP_WR_LO
  } scbm_op_t;

  typedef struct packed {
    logic [7:0] prod_hi;
    logic [7:0] prod_lo;
    logic [7:0] flags;
    logic done;
  } scbm_state_t;
endpackage : scbm_pkg

// file: scbm_mul_if.sv
// interface: operands and product between core and multiplier array
`timescale 1ns/10ps
interface scbm_mul_if;
  logic [7:0] op_a;
  logic [7:0] op_b;
  logic [15:0] product;
  modport core (output op_a, output op_b, input product);
  modport arr (input op_a, input op_b, output product);
endinterface : scbm_mul_if

// file: scbm_array.sv
// combinational unsigned 8 by 8 multiplier array
`timescale 1ns/10ps
module scbm_array
  import scbm_pkg::*;
(
  scbm_mul_if.arr mi
);
  // zero-extended operands give the full unsigned product
  assign mi.product = {8'h00, mi.op_a} * {8'h00, mi.op_b};
endmodule : scbm_array

// file: scbm_soft_model.sv
// partner model: software signed correction of a byte product
`timescale 1ns/10ps
module scbm_soft_model (
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic [7:0] hi,
  output logic [7:0] signed_hi
);
  // subtract other operand for each negative one
  assign signed_hi = hi - (b[7] ? a : 8'h00) - (a[7] ? b : 8'h00);
endmodule : scbm_soft_model

// file: tb_single_cycle_byte_multiplier.sv
// testbench: random multiply and write traffic against a model
`timescale 1ns/10ps
module tb_single_cycle_byte_multiplier;
  logic clk = 1'b0, rst = 1'b1, mul_exec = 1'b0, mul_done;
  logic wr_high = 1'b0, wr_low = 1'b0, flags_we = 1'b0, ed = 1'b0;
  logic [7:0] working_register = 8'h00, file_operand = 8'h00;
  logic [7:0] wr_data = 8'h00, flags_wdata = 8'h00, signed_hi;
  logic [7:0] product_high_byte, product_low_byte, arithmetic_status_register;
  logic [7:0] eh = 8'h00, el = 8'h00, ef = 8'h00, ma = 8'h00, mb = 8'h00;
  logic [15:0] p, x, y;
  logic [31:0] acc, prod32;
  logic signed [15:0] ps;
  int fail_count = 0, compares = 0, cyc = 0;
  bit [31:0] r;
  always #5 clk = ~clk;
  scbm_core u_scbm_core (.clk(clk), .rst(rst), .mul_exec(mul_exec),
    .working_register(working_register), .file_operand(file_operand),
    .wr_high(wr_high), .wr_low(wr_low), .wr_data(wr_data),
    .flags_we(flags_we), .flags_wdata(flags_wdata),
    .product_high_byte(product_high_byte),
    .product_low_byte(product_low_byte),
    .arithmetic_status_register(arithmetic_status_register),
    .mul_done(mul_done));
  scbm_soft_model u_scbm_soft_model (.a(ma), .b(mb),
    .hi(product_high_byte), .signed_hi(signed_hi));
  task conclude();
    if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %h %h", $time, seen, exp);
    end
  endtask : check
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      conclude();
    end
  end
  // model sees the inputs the design samples at the same edge
  always @(posedge clk) begin
    if (rst) begin
      ed = 1'b0;
      eh = 8'h00;
      el = 8'h00;
      ef = 8'h00;
    end else begin
      ed = mul_exec;
      if (mul_exec) begin
        p = working_register * file_operand;
        {eh, el} = p;
        ma = working_register;
        mb = file_operand;
      end else begin
        if (wr_high) eh = wr_data;
        if (wr_low) el = wr_data;
        if (flags_we) ef = flags_wdata;
      end
    end
  end
  always @(negedge clk) if (!rst) begin
    check({product_high_byte, product_low_byte},
      {eh, el});
    check(16'(arithmetic_status_register), 16'(ef));
    check(16'(mul_done), 16'(ed));
    ps = $signed(ma) * $signed(mb);
    if (ed) check(16'(signed_hi), 16'(ps[15:8]));
  end
  initial begin
    void'($urandom(73913));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 1500; i++) begin
      @(posedge clk);
      r = $urandom;
      // second reset in mid-run, held for two edges
      rst <= (i == 750 || i == 751);
      mul_exec <= r[0] & r[1];
      wr_high <= r[2];
      wr_low <= r[3];
      flags_we <= r[4];
      working_register <= (r[7:6] == 2'h0) ? 8'hFF :
        (r[7:5] == 3'h7) ? 8'h00 : r[15:8];
      file_operand <= (r[6:5] == 2'h0) ? 8'hFF :
        (r[7:5] == 3'h6) ? 8'h00 : r[23:16];
      wr_data <= r[31:24];
      flags_wdata <= ~r[31:24];
    end
    // 32-bit product from four weighted byte partial products
    x = 16'($urandom);
    y = 16'($urandom);
    acc = 32'h00000000;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      mul_exec <= 1'b1;
      wr_high <= 1'b0;
      wr_low <= 1'b0;
      flags_we <= 1'b0;
      working_register <= k[1] ? x[15:8] : x[7:0];
      file_operand <= k[0] ? y[15:8] : y[7:0];
      @(posedge clk);
      mul_exec <= 1'b0;
      @(negedge clk);
      acc = acc + (32'({product_high_byte, product_low_byte}) <<
        (8 * (k[1] + k[0])));
    end
    prod32 = x * y;
    check(acc[31:16], prod32[31:16]);
    check(acc[15:0], prod32[15:0]);
    conclude();
  end
endmodule : tb_single_cycle_byte_multiplier
